// [ccsup_assertions.sv]
// concurrent checks on the supervision block ports
`timescale 1ns/100ps
module ccsup_chk (
   input wire mclk, // clock
   input wire rst_b, // reset, active low
   input wire hsel, // bus select
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write
   input wire hready, // bus ready
   input wire hreadyout, // slave ready
   input wire hresp, // response
   input wire meas_vld, // measurement strobe
   input wire block_in, // blocking level
   input wire sup_start, // start
   input wire sup_blocked, // blocked
   input wire sup_alarm // alarm
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_alarm_has_start: assert property (sup_alarm |-> sup_start)
      else $error("alarm without start");
   a_blocked_no_start: assert property (sup_blocked |-> !sup_start)
      else $error("blocked and start together");
   a_blocked_no_alarm: assert property (sup_blocked |-> !sup_alarm)
      else $error("blocked and alarm together");
   a_blocked_by_input: assert property ($rose(sup_blocked)
      |-> $past(meas_vld && block_in, 3))
      else $error("blocked without latched block");
   a_moves_on_step: assert property (!$stable({sup_start, sup_blocked, sup_alarm})
      |-> $past(meas_vld, 2) || $past(meas_vld, 3) || $past(meas_vld, 4))
      else $error("indication changed outside a step");
   a_block_clears_start: assert property (meas_vld && block_in |-> ##[2:4] !sup_start)
      else $error("start kept while blocked");
   a_wait_once: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   a_wait_cause: assert property (!hreadyout
      |-> $past(hsel && htrans[1] && hwrite && hready) && htrans[1] && !hwrite)
      else $error("wait state without write then read");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   c_alarm: cover property ($rose(sup_alarm));
   c_blocked: cover property ($rose(sup_blocked));
   c_wait: cover property ($fell(hreadyout));
endmodule // ccsup_chk

bind ccsup_top ccsup_chk u_chk (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .meas_vld(meas_vld), .block_in(block_in), .sup_start(sup_start),
   .sup_blocked(sup_blocked), .sup_alarm(sup_alarm));

// [ccsup_cmp.v]
// threshold comparator with release hysteresis
`timescale 1ns/100ps
`include "ccsup_defines.vh"

module ccsup_cmp (
   input wire mclk,          // system clock
   input wire rst_s_b,       // synchronised reset, active low
   input wire upd,           // evaluate on this cycle
   input wire under,         // 1: asserts below the threshold
   input wire [79:0] meas,   // scaled measured value
   input wire [79:0] t_set,  // scaled pick-up threshold
   input wire [79:0] t_rel,  // scaled release threshold
   output reg hit            // comparison state
);

   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         hit <= 1'b0;
      end else if (upd) begin
         if (!hit) begin
            hit <= under ? (meas < t_set) : (meas > t_set);
         end else begin
            hit <= under ? !(meas > t_rel) : !(meas < t_rel);
         end
      end
   end

endmodule // ccsup_cmp

// [ccsup_cordic.v]
// iterative vectoring unit: magnitude and angle of a phasor
`timescale 1ns/100ps
`include "ccsup_defines.vh"

module ccsup_cordic (
   input wire mclk,                 // system clock
   input wire rst_s_b,              // synchronised reset, active low
   input wire go,                   // start pulse
   input wire signed [39:0] x_in,   // real part
   input wire signed [39:0] y_in,   // imaginary part
   output reg done,                 // result pulse
   output reg [39:0] mag,           // magnitude, input units
   output reg signed [15:0] ang     // angle in hundredths of a degree
);

   // twelve fraction bits keep small shifted terms from sticking at -1
   reg signed [51:0] x_r;
   reg signed [51:0] y_r;
   wire signed [51:0] x_sc;
   wire signed [51:0] y_sc;
   reg signed [15:0] z_r;
   reg [3:0] it_r;
   reg busy_r;
   wire [60:0] mag_full;

   // arctangent of 2^-i in hundredths of a degree
   function [15:0] atan_t;
      input [3:0] i;
      begin
         case (i)
            4'h0: atan_t = 16'h1194;
            4'h1: atan_t = 16'h0A61;
            4'h2: atan_t = 16'h057C;
            4'h3: atan_t = 16'h02C9;
            4'h4: atan_t = 16'h0166;
            4'h5: atan_t = 16'h00B3;
            4'h6: atan_t = 16'h005A;
            4'h7: atan_t = 16'h002D;
            4'h8: atan_t = 16'h0016;
            4'h9: atan_t = 16'h000B;
            4'hA: atan_t = 16'h0006;
            default: atan_t = 16'h0003;
         endcase
      end
   endfunction

   // remove the iteration gain
   assign mag_full = x_r[51:0] * `CCS_CORD_GAIN;
   assign x_sc = {x_in, 12'h000};
   assign y_sc = {y_in, 12'h000};

   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         x_r <= 52'h0000000000000;
         y_r <= 52'h0000000000000;
         z_r <= 16'h0000;
         it_r <= 4'h0;
         busy_r <= 1'b0;
         done <= 1'b0;
         mag <= 40'h0000000000;
         ang <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (go) begin
            busy_r <= 1'b1;
            it_r <= 4'h0;
            // left half plane is turned by half a circle first
            if (x_in < 0) begin
               x_r <= -x_sc;
               y_r <= -y_sc;
               z_r <= (y_in < 0) ? `CCS_ANG_M180 : `CCS_ANG_P180;
            end else begin
               x_r <= x_sc;
               y_r <= y_sc;
               z_r <= 16'h0000;
            end
         end else if (busy_r) begin
            if (y_r >= 0) begin
               x_r <= x_r + (y_r >>> it_r);
               y_r <= y_r - (x_r >>> it_r);
               z_r <= z_r + atan_t(it_r);
            end else begin
               x_r <= x_r - (y_r >>> it_r);
               y_r <= y_r + (x_r >>> it_r);
               z_r <= z_r - atan_t(it_r);
            end
            it_r <= it_r + 4'h1;
            if (it_r == `CCS_CORD_ITER - 4'h1) begin
               busy_r <= 1'b0;
            end
         end else if (it_r == `CCS_CORD_ITER) begin
            it_r <= 4'h0;
            done <= 1'b1;
            mag <= mag_full[60:21];
            ang <= z_r;
         end
      end
   end

endmodule // ccsup_cordic

// [ccsup_defines.vh]
// constants of the current circuit supervision block
`ifndef CCSUP_DEFINES_VH
`define CCSUP_DEFINES_VH

// register byte offsets
`define CCS_A_CTRL 8'h00
`define CCS_A_HIGH 8'h04
`define CCS_A_LOW 8'h08
`define CCS_A_RATIO 8'h0C
`define CCS_A_SEQ 8'h10
`define CCS_A_SUM 8'h14
`define CCS_A_DELAY 8'h18
`define CCS_A_STATUS 8'h1C
`define CCS_A_DMAG 8'h20
`define CCS_A_DANG 8'h24
`define CCS_A_TIMER 8'h28

// control fields
`define CCS_CTRL_SEL_LSB 0
`define CCS_CTRL_SEL_MSB 1
`define CCS_CTRL_DIR 2

// residual channel selection
`define CCS_RES_NONE 2'h0
`define CCS_RES_I01 2'h1
`define CCS_RES_I02 2'h2

// reset values
`define CCS_RST_CTRL 3'h0
`define CCS_RST_HIGH 12'h078
`define CCS_RST_LOW 12'h00A
`define CCS_RST_RATIO 14'h03E8
`define CCS_RST_SEQ 14'h1324
`define CCS_RST_SUM 12'h00A
`define CCS_RST_DELAY 19'h00064

// status bit positions
`define CCS_ST_START 0
`define CCS_ST_BLOCKED 1
`define CCS_ST_ALARM 2
`define CCS_ST_COND 3
`define CCS_ST_HI 4
`define CCS_ST_LOABV 5
`define CCS_ST_LOBLW 6
`define CCS_ST_RATIO 7
`define CCS_ST_SEQ 8
`define CCS_ST_SUM 9
`define CCS_ST_BLKIN 10

// hysteresis and scaling factors
`define CCS_K100 7'h64
`define CCS_K97 7'h61
`define CCS_K103 7'h67
`define CCS_SCALE4 14'h2710
`define CCS_SCALE12 40'hE8D4A51000
`define CCS_SIN60 10'sh1BB

// vector unit
`define CCS_CORD_ITER 4'hC
`define CCS_CORD_GAIN 9'h137
`define CCS_ANG_P180 16'h4650
`define CCS_ANG_M180 16'hB9B0

`endif

// [ccsup_fe_model.sv]
// measurement front end: balanced phasors from magnitudes, periodic strobe
`timescale 1ns/100ps
module ccsup_fe_model (
   input wire mclk, // clock
   input wire signed [15:0] m1, // phase 1 magnitude
   input wire signed [15:0] m2, // phase 2 magnitude
   input wire signed [15:0] m3, // phase 3 magnitude
   input wire signed [15:0] r1, // first residual, real
   input wire signed [15:0] r2, // second residual, real
   output logic meas_vld, // strobe
   output logic signed [15:0] ph [0:9] // l1..l3, i01, i02 as re/im
);
   logic [5:0] cnt_r = 6'h00;
   // program cycle shortened to 40 clocks
   always @(posedge mclk) begin
      cnt_r <= (cnt_r == 6'h27) ? 6'h00 : cnt_r + 6'h01;
      meas_vld <= (cnt_r == 6'h27);
   end
   // phases at 0, -120 and +120 degrees
   always @(posedge mclk) begin
      ph[0] <= m1;
      ph[1] <= 16'sh0000;
      ph[2] <= -(m2 >>> 1);
      ph[3] <= -((m2 * 32'sd866) / 32'sd1000);
      ph[4] <= -(m3 >>> 1);
      ph[5] <= (m3 * 32'sd866) / 32'sd1000;
      ph[6] <= r1;
      ph[7] <= 16'sh0000;
      ph[8] <= r2;
      ph[9] <= 16'sh0000;
   end
   initial meas_vld = 1'b0;
endmodule // ccsup_fe_model

// [ccsup_top.v]
// current circuit supervision: measurement tests, alarm timing and bus registers
// Operation
// - alarm condition is the conjunction of the tests, the sum test only if a residual is selected
// - 5 ms phasors in, sequence currents derived
// - residual select none, first, second input
// - condition starts timer, alarm after delay
// - release points at 97 and 103 percent
// - one threshold, any phase asserts the test
// - upper threshold default 1.20, inhibits activation
// - lower threshold default 0.10, must be met
// - min/max ratio below setting, default 10.00%
// - sequence ratio above setting, default 49.00%
// - lost phase gives sequence ratio one half
// - sum-residual difference above setting, default 0.10
// - delay in 5 ms steps, default 0.5 s
// - settings change live without restart
// - read-only difference magnitude and angle
// - blocking sampled at program cycle start
// - unblocked condition raises start and timing
// - blocked condition raises blocked, no timing
// - blocking after start clears start, releases
// - definite time delay only
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "ccsup_defines.vh"

module ccsup_top (
   input wire mclk,                  // 50 MHz system clock
   input wire rst_b,                 // reset, active low, asynchronous
   input wire hsel,                  // ahb slave select
   input wire [31:0] haddr,          // ahb address
   input wire [1:0] htrans,          // ahb transfer type
   input wire hwrite,                // ahb write
   input wire [2:0] hsize,           // ahb size, word only
   input wire [31:0] hwdata,         // ahb write data
   input wire hready,                // ahb bus ready
   output wire hreadyout,            // ahb slave ready
   output wire hresp,                // ahb response, always okay
   output reg [31:0] hrdata,         // ahb read data
   input wire meas_vld,              // new measurement, one pulse per 5 ms
   input wire signed [15:0] il1_re,  // phase 1 real, hundredths of nominal
   input wire signed [15:0] il1_im,  // phase 1 imaginary
   input wire signed [15:0] il2_re,  // phase 2 real
   input wire signed [15:0] il2_im,  // phase 2 imaginary
   input wire signed [15:0] il3_re,  // phase 3 real
   input wire signed [15:0] il3_im,  // phase 3 imaginary
   input wire signed [15:0] i01_re,  // first residual real
   input wire signed [15:0] i01_im,  // first residual imaginary
   input wire signed [15:0] i02_re,  // second residual real
   input wire signed [15:0] i02_im,  // second residual imaginary
   input wire block_in,              // blocking input, active high
   output wire sup_start,            // start indication
   output wire sup_blocked,          // blocked indication
   output wire sup_alarm             // supervision alarm
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_ALARM = 2'h2;
   localparam ST_BLK = 2'h3;

   reg rst_m_r;
   reg rst_s_r;
   wire rst_s_b;

   // settings
   reg [2:0] ctrl_r;
   reg [11:0] high_r;
   reg [11:0] low_r;
   reg [13:0] ratio_r;
   reg [13:0] seq_r;
   reg [11:0] sum_r;
   reg [18:0] delay_r;

   // bus slave
   reg wr_ph_r;
   reg [7:0] wa_r;
   reg [31:0] rd_nxt;
   wire ahb_go;

   // latched measurement
   reg signed [15:0] ph_re_r [0:2];
   reg signed [15:0] ph_im_r [0:2];
   reg signed [15:0] res_re_r;
   reg signed [15:0] res_im_r;
   reg blk_r;
   reg eval_r;
   reg fsm_r;

   // supervision state
   reg [1:0] st_r;
   reg [18:0] cnt_r;
   reg [19:0] dmag_r;
   reg signed [15:0] dang_r;
   reg cord_sel_r;
   reg cord_go_r;

   wire [32:0] m2 [0:2];
   wire [2:0] hi_hit;
   wire [2:0] abv_hit;
   wire [2:0] blw_hit;
   wire ratio_hit;
   wire seq_hit;
   wire sum_hit;
   wire sum_used;
   wire cond;
   wire [31:0] status;

   // release of the reset through two flip-flops
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_s_r <= rst_m_r;
      end
   end
   assign rst_s_b = rst_s_r;

   // ahb-lite slave, zero wait except a read right behind a write
   assign ahb_go = hsel & htrans[1] & hready;
   assign hreadyout = ~(wr_ph_r & hsel & htrans[1] & ~hwrite);
   assign hresp = 1'b0;

   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         wr_ph_r <= 1'b0;
         wa_r <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         wr_ph_r <= ahb_go & hwrite;
         if (ahb_go) begin
            wa_r <= haddr[7:0];
         end
         if (ahb_go & ~hwrite) begin
            hrdata <= rd_nxt;
         end
      end
   end

   // writes take effect at the next evaluation, supervision keeps running
   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         ctrl_r <= `CCS_RST_CTRL;
         high_r <= `CCS_RST_HIGH;
         low_r <= `CCS_RST_LOW;
         ratio_r <= `CCS_RST_RATIO;
         seq_r <= `CCS_RST_SEQ;
         sum_r <= `CCS_RST_SUM;
         delay_r <= `CCS_RST_DELAY;
      end else if (wr_ph_r) begin
         case (wa_r)
            `CCS_A_CTRL: ctrl_r <= hwdata[2:0];
            `CCS_A_HIGH: high_r <= hwdata[11:0];
            `CCS_A_LOW: low_r <= hwdata[11:0];
            `CCS_A_RATIO: ratio_r <= hwdata[13:0];
            `CCS_A_SEQ: seq_r <= hwdata[13:0];
            `CCS_A_SUM: sum_r <= hwdata[11:0];
            `CCS_A_DELAY: delay_r <= hwdata[18:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   always @* begin
      rd_nxt = 32'h00000000;
      case (haddr[7:0])
         `CCS_A_CTRL: rd_nxt[2:0] = ctrl_r;
         `CCS_A_HIGH: rd_nxt[11:0] = high_r;
         `CCS_A_LOW: rd_nxt[11:0] = low_r;
         `CCS_A_RATIO: rd_nxt[13:0] = ratio_r;
         `CCS_A_SEQ: rd_nxt[13:0] = seq_r;
         `CCS_A_SUM: rd_nxt[11:0] = sum_r;
         `CCS_A_DELAY: rd_nxt[18:0] = delay_r;
         `CCS_A_STATUS: rd_nxt = status;
         `CCS_A_DMAG: rd_nxt[19:0] = dmag_r;
         `CCS_A_DANG: rd_nxt = {{16{dang_r[15]}}, dang_r};
         `CCS_A_TIMER: rd_nxt[18:0] = cnt_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // program cycle start: latch phasors, residual channel and blocking
   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         ph_re_r[0] <= 16'h0000;
         ph_im_r[0] <= 16'h0000;
         ph_re_r[1] <= 16'h0000;
         ph_im_r[1] <= 16'h0000;
         ph_re_r[2] <= 16'h0000;
         ph_im_r[2] <= 16'h0000;
         res_re_r <= 16'h0000;
         res_im_r <= 16'h0000;
         blk_r <= 1'b0;
         eval_r <= 1'b0;
         fsm_r <= 1'b0;
      end else begin
         eval_r <= meas_vld;
         fsm_r <= eval_r;
         if (meas_vld) begin
            ph_re_r[0] <= il1_re;
            ph_im_r[0] <= il1_im;
            ph_re_r[1] <= il2_re;
            ph_im_r[1] <= il2_im;
            ph_re_r[2] <= il3_re;
            ph_im_r[2] <= il3_im;
            blk_r <= block_in;
            case (ctrl_r[`CCS_CTRL_SEL_MSB:`CCS_CTRL_SEL_LSB])
               `CCS_RES_I01: begin
                  res_re_r <= ctrl_r[`CCS_CTRL_DIR] ? -i01_re : i01_re;
                  res_im_r <= ctrl_r[`CCS_CTRL_DIR] ? -i01_im : i01_im;
               end
               `CCS_RES_I02: begin
                  res_re_r <= ctrl_r[`CCS_CTRL_DIR] ? -i02_re : i02_re;
                  res_im_r <= ctrl_r[`CCS_CTRL_DIR] ? -i02_im : i02_im;
               end
               default: begin
                  res_re_r <= 16'h0000;
                  res_im_r <= 16'h0000;
               end
            endcase
         end
      end
   end

   function [79:0] sq;
      input [39:0] v;
      begin
         sq = v * v;
      end
   endfunction

   // thresholds squared, scaled by 100, 97 and 103 for hysteresis
   wire [79:0] hi_set = sq(high_r * `CCS_K100);
   wire [79:0] hi_rel = sq(high_r * `CCS_K97);
   wire [79:0] lo_set = sq(low_r * `CCS_K100);
   wire [79:0] lo_r97 = sq(low_r * `CCS_K97);
   wire [79:0] lo_r103 = sq(low_r * `CCS_K103);

   // per phase: squared magnitude and the three level tests
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_ph
         wire [79:0] am;
         assign m2[gi] = ph_re_r[gi] * ph_re_r[gi] + ph_im_r[gi] * ph_im_r[gi];
         assign am = m2[gi] * `CCS_SCALE4;
         ccsup_cmp u_hi (
            .mclk(mclk), .rst_s_b(rst_s_b), .upd(eval_r), .under(1'b0),
            .meas(am), .t_set(hi_set), .t_rel(hi_rel), .hit(hi_hit[gi]));
         ccsup_cmp u_abv (
            .mclk(mclk), .rst_s_b(rst_s_b), .upd(eval_r), .under(1'b0),
            .meas(am), .t_set(lo_set), .t_rel(lo_r97), .hit(abv_hit[gi]));
         ccsup_cmp u_blw (
            .mclk(mclk), .rst_s_b(rst_s_b), .upd(eval_r), .under(1'b1),
            .meas(am), .t_set(lo_set), .t_rel(lo_r103), .hit(blw_hit[gi]));
      end
   endgenerate

   // smallest and largest phase, compared squared without a divide
   wire [32:0] mx01 = (m2[0] > m2[1]) ? m2[0] : m2[1];
   wire [32:0] mn01 = (m2[0] > m2[1]) ? m2[1] : m2[0];
   wire [32:0] mx2 = (mx01 > m2[2]) ? mx01 : m2[2];
   wire [32:0] mn2 = (mn01 < m2[2]) ? mn01 : m2[2];
   wire [79:0] rt_a = mn2 * `CCS_SCALE12;
   wire [79:0] rt_set = sq(ratio_r * `CCS_K100) * mx2;
   wire [79:0] rt_rel = sq(ratio_r * `CCS_K103) * mx2;

   ccsup_cmp u_ratio (
      .mclk(mclk), .rst_s_b(rst_s_b), .upd(eval_r), .under(1'b1),
      .meas(rt_a), .t_set(rt_set), .t_rel(rt_rel), .hit(ratio_hit));

   // three times the sequence currents, scaled by 512 then shifted back
   wire signed [29:0] ar = ph_re_r[0] <<< 9;
   wire signed [29:0] ai = ph_im_r[0] <<< 9;
   wire signed [29:0] bhr = ph_re_r[1] <<< 8;
   wire signed [29:0] bhi = ph_im_r[1] <<< 8;
   wire signed [29:0] chr = ph_re_r[2] <<< 8;
   wire signed [29:0] chi = ph_im_r[2] <<< 8;
   wire signed [29:0] bkr = ph_re_r[1] * `CCS_SIN60;
   wire signed [29:0] bki = ph_im_r[1] * `CCS_SIN60;
   wire signed [29:0] ckr = ph_re_r[2] * `CCS_SIN60;
   wire signed [29:0] cki = ph_im_r[2] * `CCS_SIN60;
   wire signed [29:0] p1r = ar - bhr - bki - chr + cki;
   wire signed [29:0] p1i = ai + bkr - bhi - ckr - chi;
   wire signed [29:0] n2r = ar - bhr + bki - chr - cki;
   wire signed [29:0] n2i = ai - bkr - bhi + ckr - chi;
   wire signed [20:0] q1r = p1r[29:9];
   wire signed [20:0] q1i = p1i[29:9];
   wire signed [20:0] q2r = n2r[29:9];
   wire signed [20:0] q2i = n2i[29:9];
   wire [41:0] s1m2 = q1r * q1r + q1i * q1i;
   wire [41:0] s2m2 = q2r * q2r + q2i * q2i;
   wire [79:0] sq_a = s2m2 * `CCS_SCALE12;
   wire [79:0] sq_set = sq(seq_r * `CCS_K100) * s1m2;
   wire [79:0] sq_rel = sq(seq_r * `CCS_K97) * s1m2;

   ccsup_cmp u_seq (
      .mclk(mclk), .rst_s_b(rst_s_b), .upd(eval_r), .under(1'b0),
      .meas(sq_a), .t_set(sq_set), .t_rel(sq_rel), .hit(seq_hit));

   // phase sum against the residual channel
   wire signed [17:0] smr = ph_re_r[0] + ph_re_r[1] + ph_re_r[2];
   wire signed [17:0] smi = ph_im_r[0] + ph_im_r[1] + ph_im_r[2];
   wire signed [18:0] dfr = smr + res_re_r;
   wire signed [18:0] dfi = smi + res_im_r;
   wire [38:0] df2 = dfr * dfr + dfi * dfi;
   wire [79:0] sm_a = df2 * `CCS_SCALE4;
   wire [79:0] sm_set = sq(sum_r * `CCS_K100);
   wire [79:0] sm_rel = sq(sum_r * `CCS_K97);

   ccsup_cmp u_sum (
      .mclk(mclk), .rst_s_b(rst_s_b), .upd(eval_r), .under(1'b0),
      .meas(sm_a), .t_set(sm_set), .t_rel(sm_rel), .hit(sum_hit));

   assign sum_used = (ctrl_r[`CCS_CTRL_SEL_MSB:`CCS_CTRL_SEL_LSB] != `CCS_RES_NONE);
   assign cond = ~(|hi_hit) & (|abv_hit) & (|blw_hit) & ratio_hit & seq_hit
      & (~sum_used | sum_hit);

   // definite time state machine, one step per program cycle
   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         st_r <= ST_IDLE;
         cnt_r <= 19'h00000;
      end else if (fsm_r) begin
         case (st_r)
            ST_IDLE: begin
               cnt_r <= 19'h00000;
               if (cond) begin
                  if (blk_r) begin
                     st_r <= ST_BLK;
                  end else if (delay_r == 19'h00000) begin
                     st_r <= ST_ALARM;
                  end else begin
                     st_r <= ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (!cond || blk_r) begin
                  st_r <= ST_IDLE;
                  cnt_r <= 19'h00000;
               end else begin
                  cnt_r <= cnt_r + 19'h00001;
                  if (cnt_r + 19'h00001 >= delay_r) begin
                     st_r <= ST_ALARM;
                  end
               end
            end
            ST_ALARM: begin
               if (!cond || blk_r) begin
                  st_r <= ST_IDLE;
                  cnt_r <= 19'h00000;
               end
            end
            ST_BLK: begin
               if (!cond || !blk_r) begin
                  st_r <= ST_IDLE;
               end
            end
            default: begin
               st_r <= ST_IDLE;
               cnt_r <= 19'h00000;
            end
         endcase
      end
   end

   assign sup_start = (st_r == ST_RUN) | (st_r == ST_ALARM);
   assign sup_blocked = (st_r == ST_BLK);
   assign sup_alarm = (st_r == ST_ALARM);

   assign status = {21'h000000, blk_r, sum_hit, seq_hit, ratio_hit, |blw_hit,
      |abv_hit, |hi_hit, cond, sup_alarm, sup_blocked, sup_start};

   // difference magnitude, then angle of sum times conjugate residual
   wire signed [39:0] pr_re = smr * res_re_r + smi * res_im_r;
   wire signed [39:0] pr_im = smi * res_re_r - smr * res_im_r;
   wire signed [39:0] cx = cord_sel_r ? pr_re : dfr;
   wire signed [39:0] cy = cord_sel_r ? pr_im : dfi;
   wire cord_done;
   wire [39:0] cord_mag;
   wire signed [15:0] cord_ang;

   ccsup_cordic u_vec (
      .mclk(mclk),
      .rst_s_b(rst_s_b),
      .go(cord_go_r),
      .x_in(cx),
      .y_in(cy),
      .done(cord_done),
      .mag(cord_mag),
      .ang(cord_ang)
   );

   always @(posedge mclk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         cord_sel_r <= 1'b0;
         cord_go_r <= 1'b0;
         dmag_r <= 20'h00000;
         dang_r <= 16'h0000;
      end else begin
         cord_go_r <= 1'b0;
         if (fsm_r) begin
            cord_sel_r <= 1'b0;
            cord_go_r <= 1'b1;
         end else if (cord_done && !cord_sel_r) begin
            dmag_r <= (|cord_mag[39:20]) ? 20'hFFFFF : cord_mag[19:0];
            cord_sel_r <= 1'b1;
            cord_go_r <= 1'b1;
         end else if (cord_done) begin
            dang_r <= cord_ang;
         end
      end
   end

endmodule // ccsup_top

// [test_current_circuit_supervision.sv]
// bench: register access and supervision scenarios
`timescale 1ns/100ps
`include "ccsup_defines.vh"
module test_current_circuit_supervision;
   logic mclk = 1'b0, rst_b = 1'b0, hwrite = 1'b0, block_in = 1'b0, meas_vld, hreadyout;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic hresp, sup_start, sup_blocked, sup_alarm;
   logic signed [15:0] m1 = 16'sh64, m2 = 16'sh64, m3 = 16'sh64, r1 = 16'sh0, r2 = 16'sh0;
   logic signed [15:0] ph [0:9];
   int num_errors = 0, check_count = 0, i;
   logic [7:0] ra [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
   logic [31:0] rv [0:6] = '{32'h0, 32'h78, 32'hA, 32'h3E8, 32'h1324, 32'hA, 32'h64};
   initial forever #10 mclk = ~mclk;
   ccsup_fe_model u_fe (.mclk(mclk), .m1(m1), .m2(m2), .m3(m3), .r1(r1), .r2(r2),
      .meas_vld(meas_vld), .ph(ph));
   ccsup_top uut (.mclk(mclk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_vld(meas_vld),
      .il1_re(ph[0]), .il1_im(ph[1]), .il2_re(ph[2]), .il2_im(ph[3]), .il3_re(ph[4]),
      .il3_im(ph[5]), .i01_re(ph[6]), .i01_im(ph[7]), .i02_re(ph[8]), .i02_im(ph[9]),
      .block_in(block_in), .sup_start(sup_start), .sup_blocked(sup_blocked),
      .sup_alarm(sup_alarm));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // entered right after a rising edge; returns right after one
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      #1;
      while (hreadyout !== 1'b1) begin @(posedge mclk); #1; end
      @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= d;
      #1;
      while (hreadyout !== 1'b1) begin @(posedge mclk); #1; end
      @(posedge mclk);
      q = hrdata;
   endtask
   task pulse(input int n);
      repeat (n) @(posedge meas_vld);
      repeat (6) @(posedge mclk);
   endtask
   task sup(input logic s, input logic b, input logic a);
      chk({29'h0, sup_start, sup_blocked, sup_alarm}, {29'h0, s, b, a});
   endtask
   task phases(input logic signed [15:0] a, input logic signed [15:0] b,
      input logic signed [15:0] c);
      m1 <= a;
      m2 <= b;
      m3 <= c;
      @(posedge mclk);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      for (i = 0; i < 7; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk(q, rv[i]);
      end
      bus(1'b1, 8'h2C, 32'hFFFFFFFF);
      bus(1'b0, 8'h2C, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, `CCS_A_DELAY, 32'h3);
      bus(1'b0, `CCS_A_DELAY, 32'h0);
      chk(q, 32'h3);
      pulse(3);
      sup(1'b0, 1'b0, 1'b0);
      phases(16'sh0, 16'sh64, 16'sh64);
      pulse(1);
      sup(1'b1, 1'b0, 1'b0);
      pulse(2);
      sup(1'b1, 1'b0, 1'b0);
      pulse(1);
      sup(1'b1, 1'b0, 1'b1);
      block_in <= 1'b1;
      pulse(1);
      sup(1'b0, 1'b0, 1'b0);
      pulse(1);
      sup(1'b0, 1'b1, 1'b0);
      block_in <= 1'b0;
      pulse(1);
      sup(1'b0, 1'b0, 1'b0);
      pulse(1);
      sup(1'b1, 1'b0, 1'b0);
      phases(16'sh64, 16'sh64, 16'sh64);
      pulse(1);
      sup(1'b0, 1'b0, 1'b0);
      phases(16'sh0, 16'sh64, 16'sh82);
      pulse(2);
      sup(1'b0, 1'b0, 1'b0);
      phases(16'sh0, 16'sh64, 16'sh76);
      pulse(1);
      sup(1'b0, 1'b0, 1'b0);
      phases(16'sh0, 16'sh5, 16'sh5);
      pulse(2);
      sup(1'b0, 1'b0, 1'b0);
      r1 <= 16'sh64;
      bus(1'b1, `CCS_A_CTRL, {30'h0, `CCS_RES_I01});
      phases(16'sh0, 16'sh64, 16'sh64);
      pulse(2);
      sup(1'b0, 1'b0, 1'b0);
      bus(1'b1, `CCS_A_CTRL, {30'h0, `CCS_RES_I02});
      pulse(2);
      sup(1'b1, 1'b0, 1'b0);
      repeat (30) @(posedge mclk);
      bus(1'b0, `CCS_A_DMAG, 32'h0);
      chk({31'h0, q >= 32'h63 && q <= 32'h65}, 32'h1);
      tally_and_finish;
   end
endmodule // test_current_circuit_supervision
